// File: eqk_pkg.sv
// constants and types shared by the error queue and key emulation block
// How it works
// (RULE_01) each reported error number is stored in a sixteen entry internal queue; here one reported in the same cycle as a rejected key is dropped
// (RULE_02) each pop query returns one queued error number and removes it
// (RULE_03) error numbers leave the queue oldest first
// (RULE_04) each returned number carries a message string of at most 160 characters
// (RULE_05) answer is number, comma, quoted message, optional semicolon and detail
// (RULE_06) a differing front panel number is appended in parentheses in the message
// (RULE_07) an empty queue answers error number 0, no error
// (RULE_08) a seventeenth error puts overflow code -350 in the sixteenth slot instead
// (RULE_09) the overflow marker moves like any entry and leaves after those ahead
// (RULE_10) clear status empties the queue, overflow marker included
// (RULE_11) the controller supplies key codes from 0 to 51
// (RULE_12) each key code maps to a fixed front panel function by lookup table
// (RULE_13) maximum argument acts as key 51, minimum argument as key 0
// (RULE_14) last key query returns latest key, or -1 since power on or reset
// (RULE_15) last key query with maximum answers 51, with minimum answers 0
// (RULE_16) an out of range key code is ignored and pushes a data range error
`default_nettype none
package eqk_pkg;
   // ----------------------------------------
   // sizes and codes
   // ----------------------------------------
   localparam int DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam int ERR_W = 16;
   localparam int KEY_W = 8;
   localparam int FUNC_W = 6;
   localparam int MSG_MAX_CHARS = 160;
   localparam logic [ERR_W-1:0] ERR_NONE = 16'h0000;
   localparam logic [ERR_W-1:0] ERR_OVERFLOW = 16'hfea2; // -350
   localparam logic [ERR_W-1:0] ERR_DATA_RANGE = 16'hff22; // -222
   localparam logic [ERR_W-1:0] FP_NONE = 16'h0000;
   localparam logic [KEY_W-1:0] KEY_MIN = 8'h00;
   localparam logic [KEY_W-1:0] KEY_MAX = 8'h33; // 51
   localparam logic [KEY_W-1:0] KEY_NONE = 8'hff; // -1
   localparam logic [KEY_W-1:0] KEY_PRESET = 8'h1f;
   localparam logic [KEY_W-1:0] KEY_LOCAL = 8'h1b;
   localparam logic [FUNC_W-1:0] FUNC_UNUSED = 6'h3f;
   localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
   localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
   // argument qualifier of a key command or key query
   typedef enum logic [1:0] {ARG_NUM, ARG_MAX, ARG_MIN} eqk_arg_t;
endpackage
`default_nettype wire

// File: eqk_top.sv
// error queue with overflow marker and front panel key emulation
`timescale 1ns/1ps
`default_nettype none
module eqk_top
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // error reports from the instrument
   input wire logic i_err_push,
   input wire logic [eqk_pkg::ERR_W-1:0] i_err_num,
   input wire logic [eqk_pkg::ERR_W-1:0] i_err_fp_num,
   input wire logic [7:0] i_err_msg_len,
   // controller commands
   input wire logic i_err_pop,
   input wire logic i_clear_status,
   input wire logic i_reset_cmd,
   input wire logic i_key_cmd,
   input wire eqk_pkg::eqk_arg_t i_key_arg,
   input wire logic [eqk_pkg::KEY_W-1:0] i_key_code,
   input wire logic i_key_query,
   input wire eqk_pkg::eqk_arg_t i_key_query_arg,
   // error answer
   output logic o_err_valid,
   output logic [eqk_pkg::ERR_W-1:0] o_err_num,
   output logic [eqk_pkg::ERR_W-1:0] o_err_fp_num,
   output logic o_err_fp_differs,
   output logic [7:0] o_err_msg_len,
   output logic [eqk_pkg::CNT_W-1:0] o_err_count,
   // key press and key answer
   output logic o_key_press,
   output logic [eqk_pkg::FUNC_W-1:0] o_key_func,
   output logic o_key_valid,
   output logic [eqk_pkg::KEY_W-1:0] o_key_answer
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [eqk_pkg::DEPTH-1:0][eqk_pkg::ERR_W-1:0] num;
      logic [eqk_pkg::DEPTH-1:0][eqk_pkg::ERR_W-1:0] fp;
      logic [eqk_pkg::DEPTH-1:0][7:0] len;
      logic [eqk_pkg::PTR_W-1:0] rd;
      logic [eqk_pkg::PTR_W-1:0] wr;
      logic [eqk_pkg::CNT_W-1:0] cnt;
      logic err_valid;
      logic [eqk_pkg::ERR_W-1:0] err_num;
      logic [eqk_pkg::ERR_W-1:0] err_fp;
      logic [7:0] err_len;
      logic [eqk_pkg::KEY_W-1:0] last_key;
      logic key_press;
      logic [eqk_pkg::FUNC_W-1:0] key_func;
      logic key_valid;
      logic [eqk_pkg::KEY_W-1:0] key_ans;
   } eqk_state_t;

   eqk_state_t st_r;
   eqk_state_t st_nxt;

   // fixed key table; unlisted codes map to an unused function
   function automatic logic [eqk_pkg::FUNC_W-1:0] key_to_func(input logic [eqk_pkg::KEY_W-1:0] k);
      if ((k == 8'h0b) || ((k >= 8'h0f) && (k <= 8'h13)) || (k > eqk_pkg::KEY_MAX))
         return eqk_pkg::FUNC_UNUSED; // RULE_12
      else
         return k[eqk_pkg::FUNC_W-1:0]; // RULE_12
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   logic key_ok;
   logic [eqk_pkg::KEY_W-1:0] key_eff;
   logic push;
   logic [eqk_pkg::ERR_W-1:0] push_num;
   logic [eqk_pkg::ERR_W-1:0] push_fp;
   logic [7:0] push_len;
   logic pop;
   logic [eqk_pkg::PTR_W-1:0] last_slot;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.err_valid = 1'b0;
      st_nxt.key_press = 1'b0;
      st_nxt.key_valid = 1'b0;
      key_eff = i_key_code;
      if (i_key_arg == eqk_pkg::ARG_MAX)
         key_eff = eqk_pkg::KEY_MAX; // RULE_13
      else if (i_key_arg == eqk_pkg::ARG_MIN)
         key_eff = eqk_pkg::KEY_MIN; // RULE_13
      key_ok = (key_eff <= eqk_pkg::KEY_MAX);
      // a rejected key reports its own error in the same cycle; it takes the push slot
      push = i_err_push || (i_key_cmd && !key_ok); // RULE_16
      push_num = (i_key_cmd && !key_ok) ? eqk_pkg::ERR_DATA_RANGE : i_err_num;
      push_fp = (i_key_cmd && !key_ok) ? eqk_pkg::FP_NONE : i_err_fp_num;
      push_len = (i_key_cmd && !key_ok) ? 8'h11 : i_err_msg_len;
      if (push_len > 8'(eqk_pkg::MSG_MAX_CHARS))
         push_len = 8'(eqk_pkg::MSG_MAX_CHARS); // RULE_04
      pop = i_err_pop && (st_r.cnt != eqk_pkg::CNT_RESET);
      last_slot = st_r.wr - 4'h1;
      // answer to a pop query
      if (i_err_pop)
      begin
         st_nxt.err_valid = 1'b1;
         if (pop)
         begin
            st_nxt.err_num = st_r.num[st_r.rd]; // RULE_02 RULE_03
            st_nxt.err_fp = st_r.fp[st_r.rd];
            st_nxt.err_len = st_r.len[st_r.rd];
            st_nxt.rd = st_r.rd + 4'h1;
         end
         else
         begin
            st_nxt.err_num = eqk_pkg::ERR_NONE; // RULE_07
            st_nxt.err_fp = eqk_pkg::FP_NONE;
            st_nxt.err_len = 8'h08;
         end
      end
      // store; a pop in the same cycle frees a slot first
      if (push)
      begin
         if ((st_r.cnt < 5'(eqk_pkg::DEPTH)) || pop)
         begin
            st_nxt.num[st_r.wr] = push_num; // RULE_01
            st_nxt.fp[st_r.wr] = push_fp;
            st_nxt.len[st_r.wr] = push_len;
            st_nxt.wr = st_r.wr + 4'h1;
         end
         else
         begin
            st_nxt.num[last_slot] = eqk_pkg::ERR_OVERFLOW; // RULE_08 RULE_09
            st_nxt.fp[last_slot] = eqk_pkg::FP_NONE;
            st_nxt.len[last_slot] = 8'h0f;
         end
      end
      st_nxt.cnt = st_r.cnt + 5'(push && ((st_r.cnt < 5'(eqk_pkg::DEPTH)) || pop)) - 5'(pop);
      if (i_clear_status)
      begin
         st_nxt.rd = eqk_pkg::PTR_RESET; // RULE_10
         st_nxt.wr = eqk_pkg::PTR_RESET;
         st_nxt.cnt = eqk_pkg::CNT_RESET;
      end
      // key emulation
      if (i_key_cmd && key_ok)
      begin
         st_nxt.key_press = 1'b1;
         st_nxt.key_func = key_to_func(key_eff); // RULE_12
         st_nxt.last_key = key_eff; // RULE_14
      end
      if (i_reset_cmd)
         st_nxt.last_key = eqk_pkg::KEY_NONE; // RULE_14
      if (i_key_query)
      begin
         st_nxt.key_valid = 1'b1;
         if (i_key_query_arg == eqk_pkg::ARG_MAX)
            st_nxt.key_ans = eqk_pkg::KEY_MAX; // RULE_15
         else if (i_key_query_arg == eqk_pkg::ARG_MIN)
            st_nxt.key_ans = eqk_pkg::KEY_MIN; // RULE_15
         else
            st_nxt.key_ans = st_r.last_key; // RULE_14
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         st_r <= '0;
         st_r.last_key <= eqk_pkg::KEY_NONE;
         st_r.key_func <= eqk_pkg::FUNC_UNUSED;
      end
      else
         st_r <= st_nxt;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_err_valid = st_r.err_valid;
   assign o_err_num = st_r.err_num;
   assign o_err_fp_num = st_r.err_fp;
   assign o_err_fp_differs = (st_r.err_fp != eqk_pkg::FP_NONE) &&
                             (st_r.err_fp != st_r.err_num); // RULE_06 RULE_05
   assign o_err_msg_len = st_r.err_len;
   assign o_err_count = st_r.cnt;
   assign o_key_press = st_r.key_press;
   assign o_key_func = st_r.key_func;
   assign o_key_valid = st_r.key_valid;
   assign o_key_answer = st_r.key_ans;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_count_bound;
      @(posedge i_core_clk) disable iff (!i_rstn) st_r.cnt <= 5'(eqk_pkg::DEPTH);
   endproperty
   a_count_bound: assert property (p_count_bound) else $error("queue count too high"); // RULE_01

   property p_empty_answer;
      @(posedge i_core_clk) disable iff (!i_rstn)
         (i_err_pop && st_r.cnt == 5'h00) |=> (o_err_valid && o_err_num == eqk_pkg::ERR_NONE);
   endproperty
   a_empty_answer: assert property (p_empty_answer) else $error("empty pop not zero"); // RULE_07

   property p_pop_head;
      @(posedge i_core_clk) disable iff (!i_rstn)
         (i_err_pop && st_r.cnt != 5'h00) |=> (o_err_num == $past(st_r.num[st_r.rd]));
   endproperty
   a_pop_head: assert property (p_pop_head) else $error("pop not oldest"); // RULE_03

   property p_pop_count;
      @(posedge i_core_clk) disable iff (!i_rstn)
         (i_err_pop && !push && !i_clear_status && st_r.cnt != 5'h00)
            |=> (st_r.cnt == $past(st_r.cnt) - 5'h01);
   endproperty
   a_pop_count: assert property (p_pop_count) else $error("pop did not remove"); // RULE_02

   property p_overflow;
      @(posedge i_core_clk) disable iff (!i_rstn)
         (push && !pop && !i_clear_status && st_r.cnt == 5'h10)
            |=> (st_r.num[st_r.wr - 4'h1] == eqk_pkg::ERR_OVERFLOW && st_r.cnt == 5'h10);
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow marker missing"); // RULE_08

   property p_clear;
      @(posedge i_core_clk) disable iff (!i_rstn)
         i_clear_status |=> (st_r.cnt == 5'h00 && st_r.rd == st_r.wr);
   endproperty
   a_clear: assert property (p_clear) else $error("clear left entries"); // RULE_10

   property p_bad_key;
      @(posedge i_core_clk) disable iff (!i_rstn)
         (i_key_cmd && !i_reset_cmd && i_key_arg == eqk_pkg::ARG_NUM &&
          i_key_code > eqk_pkg::KEY_MAX)
            |=> (!o_key_press && st_r.last_key == $past(st_r.last_key));
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("bad key accepted"); // RULE_16

   property p_key_max;
      @(posedge i_core_clk) disable iff (!i_rstn)
         (i_key_query && i_key_query_arg == eqk_pkg::ARG_MAX)
            |=> (o_key_valid && o_key_answer == 8'h33);
   endproperty
   a_key_max: assert property (p_key_max) else $error("max query not 51"); // RULE_15

   property p_key_min_cmd;
      @(posedge i_core_clk) disable iff (!i_rstn)
         (i_key_cmd && i_key_arg == eqk_pkg::ARG_MIN && !i_reset_cmd)
            |=> (o_key_press && st_r.last_key == 8'h00);
   endproperty
   a_key_min_cmd: assert property (p_key_min_cmd) else $error("min key not 0"); // RULE_13

   property p_key_table;
      @(posedge i_core_clk) disable iff (!i_rstn)
         (i_key_cmd && i_key_arg == eqk_pkg::ARG_NUM && i_key_code == eqk_pkg::KEY_PRESET)
            |=> (o_key_func == 6'h1f);
   endproperty
   a_key_table: assert property (p_key_table) else $error("preset key mapped wrong"); // RULE_12

   property p_msg_len;
      @(posedge i_core_clk) disable iff (!i_rstn) o_err_valid |-> o_err_msg_len <= 8'ha0;
   endproperty
   a_msg_len: assert property (p_msg_len) else $error("message too long"); // RULE_04
endmodule
`default_nettype wire

// File: eqk_ctrl_model.sv
// remote controller model that issues commands to the error queue and key block
`timescale 1ns/1ps
`default_nettype none
module eqk_ctrl_model
(
   // clock
   input wire logic i_core_clk,
   // strobes: push, pop, clear, reset, key, key query
   output logic [5:0] o_stb,
   // command data
   output logic [15:0] o_num,
   output logic [15:0] o_fp,
   output logic [7:0] o_len,
   output var eqk_pkg::eqk_arg_t o_arg,
   output logic [7:0] o_key
);
   initial
   begin
      o_stb = 6'h00;
      o_num = 16'h0000;
      o_fp = 16'h0000;
      o_len = 8'h00;
      o_arg = eqk_pkg::ARG_NUM;
      o_key = 8'h00;
   end
   // one-cycle command; idle data except the argument is inverted so a stale value cannot pass for a live one
   task automatic issue(input logic [5:0] s, input logic [15:0] n, input logic [15:0] f,
                        input logic [7:0] l, input eqk_pkg::eqk_arg_t a, input logic [7:0] k);
      @(posedge i_core_clk);
      o_stb <= s;
      o_num <= n;
      o_fp <= f;
      o_len <= l;
      o_arg <= a;
      o_key <= k;
      @(posedge i_core_clk);
      o_stb <= 6'h00;
      o_num <= ~n;
      o_fp <= ~f;
      o_len <= ~l;
      o_key <= ~k;
   endtask
endmodule
`default_nettype wire

// File: eqk_tb.sv
// self-checking testbench for the error queue and key emulation block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic i_core_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic [5:0] stb;
   logic [15:0] num, fp, o_err_num, o_err_fp_num;
   logic [7:0] len, kc, o_err_msg_len, o_key_answer;
   eqk_pkg::eqk_arg_t arg;
   logic o_err_valid, o_err_fp_differs, o_key_press, o_key_valid;
   logic [4:0] o_err_count;
   logic [5:0] o_key_func;
   logic [23:0] err_q[$];
   logic [7:0] key_q[$];
   logic [5:0] func_q[$];
   int failures = 0;
   int compares = 0;
   always #50 i_core_clk = ~i_core_clk;
   eqk_ctrl_model m (.i_core_clk(i_core_clk), .o_stb(stb), .o_num(num), .o_fp(fp),
      .o_len(len), .o_arg(arg), .o_key(kc));
   eqk_top dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_err_push(stb[5]),
      .i_err_num(num), .i_err_fp_num(fp), .i_err_msg_len(len), .i_err_pop(stb[4]),
      .i_clear_status(stb[3]), .i_reset_cmd(stb[2]), .i_key_cmd(stb[1]), .i_key_arg(arg),
      .i_key_code(kc), .i_key_query(stb[0]), .i_key_query_arg(arg),
      .o_err_valid(o_err_valid), .o_err_num(o_err_num), .o_err_fp_num(o_err_fp_num),
      .o_err_fp_differs(o_err_fp_differs), .o_err_msg_len(o_err_msg_len),
      .o_err_count(o_err_count), .o_key_press(o_key_press), .o_key_func(o_key_func),
      .o_key_valid(o_key_valid), .o_key_answer(o_key_answer));
   // ----------------------------------------
   // scoreboard
   // ----------------------------------------
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // outputs are settled at the falling edge
   always @(negedge i_core_clk)
   begin
      if (o_err_valid === 1'b1)
         check({o_err_msg_len, o_err_num}, err_q.pop_front());
      if (o_key_valid === 1'b1)
         check({16'h0000, o_key_answer}, {16'h0000, key_q.pop_front()});
      if (o_key_press === 1'b1)
         check({18'h00000, o_key_func}, {18'h00000, func_q.pop_front()});
   end
   task automatic push(input logic [15:0] n, input logic [15:0] f, input logic [7:0] l);
      m.issue(6'h20, n, f, l, eqk_pkg::ARG_NUM, 8'h00);
   endtask
   task automatic pop(input logic [23:0] e);
      err_q.push_back(e);
      m.issue(6'h10, 16'h0000, 16'h0000, 8'h00, eqk_pkg::ARG_NUM, 8'h00);
   endtask
   // f[6] set means the press is expected to be refused
   task automatic key(input eqk_pkg::eqk_arg_t a, input logic [7:0] k, input logic [6:0] f);
      if (f[6] == 1'b0)
         func_q.push_back(f[5:0]);
      m.issue(6'h02, 16'h0000, 16'h0000, 8'h00, a, k);
   endtask
   task automatic ask(input eqk_pkg::eqk_arg_t a, input logic [7:0] e);
      key_q.push_back(e);
      m.issue(6'h01, 16'h0000, 16'h0000, 8'h00, a, 8'h00);
   endtask
   initial
   begin
      #200000;
      failures++;
      summarize();
   end
   initial
   begin
      logic [23:0] v[$];
      logic [15:0] n;
      logic [7:0] l;
      int i;
      void'($urandom(32'h73255b03));
      repeat (16) @(posedge i_core_clk);
      i_rstn <= 1'b1;
      pop({8'h08, eqk_pkg::ERR_NONE});
      ask(eqk_pkg::ARG_NUM, eqk_pkg::KEY_NONE);
      for (i = 0; i < 17; i++)
      begin
         n = 16'($urandom);
         l = 8'($urandom);
         v.push_back({(l > 8'ha0) ? 8'ha0 : l, n});
         push(n, 16'h0000, l);
      end
      @(negedge i_core_clk);
      check({19'h00000, o_err_count}, 24'h000010);
      v[15] = {8'h0f, eqk_pkg::ERR_OVERFLOW};
      for (i = 0; i < 16; i++)
         pop(v[i]);
      pop({8'h08, eqk_pkg::ERR_NONE});
      push(16'($urandom), 16'h0000, 8'h05);
      push(16'($urandom), 16'h0000, 8'h06);
      m.issue(6'h08, 16'h0000, 16'h0000, 8'h00, eqk_pkg::ARG_NUM, 8'h00);
      pop({8'h08, eqk_pkg::ERR_NONE});
      push(eqk_pkg::ERR_DATA_RANGE, 16'h07ee, 8'h20);
      pop({8'h20, eqk_pkg::ERR_DATA_RANGE});
      @(negedge i_core_clk);
      check({7'h00, o_err_fp_differs, o_err_fp_num}, 24'h0107ee);
      for (i = 0; i < 52; i++)
      begin
         key(eqk_pkg::ARG_NUM, 8'(i), (i == 11 || (i > 14 && i < 20)) ? 7'h3f : 7'(i));
         ask(eqk_pkg::ARG_NUM, 8'(i));
      end
      key(eqk_pkg::ARG_MAX, 8'($urandom % 52), 7'h33);
      ask(eqk_pkg::ARG_NUM, eqk_pkg::KEY_MAX);
      key(eqk_pkg::ARG_MIN, 8'($urandom % 52), 7'h00);
      ask(eqk_pkg::ARG_NUM, eqk_pkg::KEY_MIN);
      ask(eqk_pkg::ARG_MAX, eqk_pkg::KEY_MAX);
      key(eqk_pkg::ARG_NUM, 8'h34 + 8'($urandom % 204), 7'h40);
      ask(eqk_pkg::ARG_NUM, eqk_pkg::KEY_MIN);
      pop({8'h11, eqk_pkg::ERR_DATA_RANGE});
      @(negedge i_core_clk);
      check({7'h00, o_err_fp_differs, o_err_fp_num}, 24'h000000);
      m.issue(6'h04, 16'h0000, 16'h0000, 8'h00, eqk_pkg::ARG_NUM, 8'h00);
      ask(eqk_pkg::ARG_NUM, eqk_pkg::KEY_NONE);
      ask(eqk_pkg::ARG_MIN, eqk_pkg::KEY_MIN);
      repeat (4) @(posedge i_core_clk);
      check(24'(err_q.size() + key_q.size() + func_q.size()), 24'h000000);
      summarize();
   end
endmodule
`default_nettype wire
